/* File: include/offset_pkg.sv */
package offset_pkg;

    // Geometry of the stream offset fields
    localparam int STREAMS = 16;
    localparam int FIELD_W = 4;
    localparam int REG_W = 16;
    localparam int ADDR_W = 4;
    localparam int OFS_REGS = 4;
    localparam int EDGE_BIT = 0;
    localparam int WHOLE_LSB = 1;
    localparam int WHOLE_W = 3;

    // Register addresses, word indexed
    localparam logic [3:0] ADDR_OFS0 = 4'h3;
    localparam logic [3:0] ADDR_OFS3 = 4'h6;
    localparam logic [3:0] ADDR_CTRL = 4'h7;
    localparam logic [3:0] ADDR_STAT = 4'h8;

    // Values after reset
    localparam logic [15:0] OFS_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // Control and status bit positions
    localparam int CTRL_GCI_BIT = 0;
    localparam int CTRL_EN_BIT = 1;
    localparam int STAT_PHASE_BIT = 0;
    localparam int STAT_FRAME_BIT = 1;
    localparam int STAT_OVR_BIT = 2;

    // Half-period counts: largest shift, counter ceiling, word push point
    localparam logic [3:0] MAX_HALF = 4'h9;
    localparam logic [3:0] HP_SAT = 4'hf;
    localparam logic [3:0] LAST_HP = 4'ha;

    // Alignment sequencer
    typedef enum logic [0:0] {
        ALIGN_IDLE = 1'b0,
        ALIGN_RUN = 1'b1
    } align_state_t;

endpackage

/* File: include/word_if.sv */
`timescale 1ns/10ps
// Valid/ready word channel between the aligner and its buffer
interface word_if #(parameter int W = 16);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: hw/input_sync.sv */
`timescale 1ns/10ps
module input_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // Two stages; only the second stage is visible outside
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

/* File: hw/word_buffer.sv */
`timescale 1ns/10ps
module word_buffer (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Filling side and draining side
    word_if.snk wr,
    word_if.src rd
);

    logic tail_valid_reg;
    logic [$bits(wr.data)-1:0] tail_reg;

    // Ready comes from a flop so the source never sees a combinational path
    assign wr.ready = ~tail_valid_reg;

    // Head entry drives the drain side directly from flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd.valid <= 1'b0;
            rd.data <= '0;
            tail_valid_reg <= 1'b0;
            tail_reg <= '0;
        end else if (rd.valid && rd.ready) begin
            if (tail_valid_reg) begin
                rd.data <= tail_reg;
                tail_valid_reg <= 1'b0;
            end else if (wr.valid) begin
                rd.data <= wr.data;
            end else begin
                rd.valid <= 1'b0;
            end
        end else if (wr.valid && !tail_valid_reg) begin
            if (!rd.valid) begin
                rd.data <= wr.data;
                rd.valid <= 1'b1;
            end else begin
                tail_reg <= wr.data;
                tail_valid_reg <= 1'b1;
            end
        end
    end

endmodule

/* File: hw/stream_offset_top.sv */
`timescale 1ns/10ps
// Functional notes
// - Each of the 16 streams has a 4-bit field, four to a 16-bit register, edge bit lowest.
// - The three whole-offset bits give, in binary, the whole bit-clock periods of delay.
// - Outside GCI mode, edge bit 0 samples on the rising clock edge, 1 on the falling edge.
// - In GCI mode, edge bit 0 samples on the falling clock edge, 1 on the rising edge.
// - A field of all zeros gives no shift, and that is the value after reset.
// - An edge bit of 1 adds half a clock period on top of the whole periods.
// - Shifts run from 0 to 4.5 periods in half steps; larger codes are held at 4.5.
// - The phase bit reads 1 if the frame edge met a high clock, 0 if it met a low clock.
// - The four offset registers reset to zero and are read and written from address 03h.
module stream_offset_top
    import offset_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [REG_W-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [REG_W-1:0] rd_data,
    // Serial side pins
    input wire logic bit_clk_pin,
    input wire logic frame_pin,
    input wire logic [STREAMS-1:0] serial_in,
    // Aligned word output
    output logic out_valid,
    output logic [STREAMS-1:0] out_data,
    input wire logic out_ready
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [REG_W-1:0] offset_reg [OFS_REGS];
    logic [REG_W-1:0] ctrl_reg;
    logic phase_reg;
    logic frame_seen_reg;
    logic overrun_reg;
    logic bit_clk_prev_reg;
    logic frame_prev_reg;
    logic [3:0] hp_cnt_reg;
    logic [STREAMS-1:0] aligned_reg;
    align_state_t state_reg;
    align_state_t state_next;
    logic [STREAMS+1:0] sync_q;
    logic bit_clk_s;
    logic frame_s;
    logic [STREAMS-1:0] serial_s;
    logic gci_mode;
    logic word_enable;
    logic edge_evt;
    logic edge_rise;
    logic frame_evt;
    logic push;
    logic [STREAMS-1:0] strobe;
    logic [FIELD_W-1:0] field [STREAMS];
    logic [3:0] delay_half [STREAMS];
    logic [REG_W-1:0] read_mux;
    logic [ADDR_W-1:0] ofs_index;
    logic any_ofs_write_reg;

    word_if #(.W(STREAMS)) push_if ();
    word_if #(.W(STREAMS)) drain_if ();

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Clock, frame and data share one delay so their relative timing survives
    input_sync #(.W(STREAMS + 2)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({bit_clk_pin, frame_pin, serial_in}),
        .q(sync_q)
    );

    assign bit_clk_s = sync_q[STREAMS+1];
    assign frame_s = sync_q[STREAMS];
    assign serial_s = sync_q[STREAMS-1:0];

    // Previous values for edge detection, taken after the synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bit_clk_prev_reg <= 1'b0;
            frame_prev_reg <= 1'b0;
        end else begin
            bit_clk_prev_reg <= bit_clk_s;
            frame_prev_reg <= frame_s;
        end
    end

    // Every bit clock edge is one half period
    assign edge_evt = bit_clk_s ^ bit_clk_prev_reg;
    assign edge_rise = bit_clk_s & ~bit_clk_prev_reg;

    // Frame is marked by its falling edge, or its rising edge in GCI mode
    assign gci_mode = ctrl_reg[CTRL_GCI_BIT];
    assign word_enable = ctrl_reg[CTRL_EN_BIT];
    assign frame_evt = gci_mode ? (frame_s & ~frame_prev_reg) : (~frame_s & frame_prev_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes

    assign ofs_index = addr - ADDR_OFS0;

    // Offset registers storage, all fields zero after reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < OFS_REGS; i++) begin
                offset_reg[i] <= OFS_RESET;
            end
        end else if (wr_stb && addr >= ADDR_OFS0 && addr <= ADDR_OFS3) begin
            offset_reg[ofs_index[1:0]] <= wr_data;
        end
    end

    // Control holds the framing mode and the word output enable
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_stb && addr == ADDR_CTRL) begin
            ctrl_reg <= wr_data;
        end
    end

    // Helper for the reset check below
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            any_ofs_write_reg <= 1'b0;
        end else if (wr_stb && addr >= ADDR_OFS0 && addr <= ADDR_OFS3) begin
            any_ofs_write_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Phase measurement

    // Clock level caught at the frame edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= 1'b0;
            frame_seen_reg <= 1'b0;
        end else if (frame_evt) begin
            phase_reg <= bit_clk_s;
            frame_seen_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Alignment sequencer and half-period counter

    // Sampling starts only once a frame reference exists
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ALIGN_IDLE: begin
                if (frame_evt) begin
                    state_next = ALIGN_RUN;
                end
            end
            ALIGN_RUN: begin
                state_next = ALIGN_RUN;
            end
            default: begin
                state_next = ALIGN_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ALIGN_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Half periods since the frame edge, saturating past the largest shift
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hp_cnt_reg <= 4'h0;
        end else if (frame_evt) begin
            hp_cnt_reg <= 4'h0;
        end else if (edge_evt && hp_cnt_reg != HP_SAT) begin
            hp_cnt_reg <= hp_cnt_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-stream field decode and sampling strobe

    genvar n;
    generate
        for (n = 0; n < STREAMS; n++) begin : g_stream
            // Four fields per register, stream n in bits 4*(n%4)
            assign field[n] = offset_reg[n / 4][(n % 4) * FIELD_W +: FIELD_W];

            // Whole periods and edge bit form a half-period count directly
            // The edge bit is the half-period least significant bit
            // Codes beyond 4.5 periods are held at 4.5; this keeps every
            // strobe threshold below the LAST_HP point at which words are pushed
            assign delay_half[n] = (field[n] > MAX_HALF) ? MAX_HALF : field[n];

            // Edge polarity from edge bit and framing mode
            assign strobe[n] = (state_reg == ALIGN_RUN) && edge_evt
                && (edge_rise == ~(field[n][EDGE_BIT] ^ gci_mode))
                && (hp_cnt_reg >= delay_half[n]);

            // Stream bit captured on its own strobe
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    aligned_reg[n] <= 1'b0;
                end else if (strobe[n]) begin
                    aligned_reg[n] <= serial_s[n];
                end
            end

            a_no_early_strobe : assert property (
                @(posedge clock) disable iff (!rst_n)
                strobe[n] |-> (hp_cnt_reg >= {field[n][3:1], 1'b0}))
                else $error("strobe before whole-period offset");

            a_half_step : assert property (
                @(posedge clock) disable iff (!rst_n)
                (strobe[n] && field[n] <= MAX_HALF && field[n][EDGE_BIT])
                |-> (hp_cnt_reg >= {field[n][3:1], 1'b1}))
                else $error("edge bit did not add half a period");

            a_edge_plain : assert property (
                @(posedge clock) disable iff (!rst_n)
                (strobe[n] && !gci_mode) |-> (edge_rise == !field[n][EDGE_BIT]))
                else $error("wrong sampling edge outside GCI mode");

            a_edge_gci : assert property (
                @(posedge clock) disable iff (!rst_n)
                (strobe[n] && gci_mode) |-> (edge_rise == field[n][EDGE_BIT]))
                else $error("wrong sampling edge in GCI mode");

            a_zero_shift : assert property (
                @(posedge clock) disable iff (!rst_n)
                (field[n] == 4'h0 && state_reg == ALIGN_RUN && edge_evt
                    && (edge_rise != gci_mode)) |-> strobe[n])
                else $error("zero field did not sample at once");

            a_shift_limit : assert property (
                @(posedge clock) disable iff (!rst_n)
                (state_reg == ALIGN_RUN && edge_evt && hp_cnt_reg >= MAX_HALF
                    && (edge_rise == ~(field[n][EDGE_BIT] ^ gci_mode))) |-> strobe[n])
                else $error("strobe missing past largest shift");

            a_strobe_capture : assert property (
                @(posedge clock) disable iff (!rst_n)
                strobe[n] |=> (aligned_reg[n] == $past(serial_s[n])))
                else $error("aligned bit not taken on strobe");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Word buffer

    // One word per bit period, after every stream has had its latest strobe
    assign push = (state_reg == ALIGN_RUN) && word_enable && edge_evt
        && (edge_rise != gci_mode) && (hp_cnt_reg >= LAST_HP);

    assign push_if.valid = push;
    assign push_if.data = aligned_reg;
    assign drain_if.ready = out_ready;

    // The buffer's head flops drive the output pins
    word_buffer u_buffer (
        .clock(clock),
        .rst_n(rst_n),
        .wr(push_if.snk),
        .rd(drain_if.src)
    );

    assign out_valid = drain_if.valid;
    assign out_data = drain_if.data;

    // Overrun is sticky; a new loss wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            overrun_reg <= 1'b0;
        end else if (push && !push_if.ready) begin
            overrun_reg <= 1'b1;
        end else if (wr_stb && addr == ADDR_STAT && wr_data[STAT_OVR_BIT]) begin
            overrun_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register reads

    // Unmapped addresses read as zero
    always_comb begin
        read_mux = '0;
        case (addr)
            4'h3, 4'h4, 4'h5, 4'h6: begin
                read_mux = offset_reg[ofs_index[1:0]];
            end
            ADDR_CTRL: begin
                read_mux = ctrl_reg;
            end
            ADDR_STAT: begin
                read_mux[STAT_PHASE_BIT] = phase_reg;
                read_mux[STAT_FRAME_BIT] = frame_seen_reg;
                read_mux[STAT_OVR_BIT] = overrun_reg;
            end
            default: begin
                read_mux = '0;
            end
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_stb) begin
            rd_data <= read_mux;
        end else begin
            rd_data <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register and measurement checks

    a_field_write : assert property (
        @(posedge clock) disable iff (!rst_n)
        (wr_stb && addr == 4'h4) |=> (field[4] == $past(wr_data[3:0]))
            && (field[7] == $past(wr_data[15:12])))
        else $error("second register does not map streams 4 to 7");

    a_reset_zero : assert property (
        @(posedge clock) disable iff (!rst_n)
        (rd_stb && !any_ofs_write_reg && addr >= ADDR_OFS0 && addr <= ADDR_OFS3)
            |=> (rd_data == OFS_RESET))
        else $error("offset register not zero after reset");

    a_write_read : assert property (
        @(posedge clock) disable iff (!rst_n)
        ((wr_stb && addr >= ADDR_OFS0 && addr <= ADDR_OFS3)
            ##1 (rd_stb && !wr_stb && addr == $past(addr)))
            |=> (rd_data == $past(wr_data, 2)))
        else $error("offset register read back differs");

    a_phase_level : assert property (
        @(posedge clock) disable iff (!rst_n)
        frame_evt |=> (phase_reg == $past(bit_clk_s)) && frame_seen_reg)
        else $error("phase bit not the clock level at frame edge");

    a_counter_clear : assert property (
        @(posedge clock) disable iff (!rst_n)
        (frame_evt ##1 !frame_evt[*2]) |-> (hp_cnt_reg <= 4'h2))
        else $error("half-period count not restarted at frame");

endmodule

/* File: test/serial_source.sv */
`timescale 1ns/10ps
// Far-side model: free-running bit clock, frame pulse and sixteen serial streams
module serial_source
    import offset_pkg::*;
#(
    parameter int QUARTER_NS = 100,
    parameter int FRAME_BITS = 16
) (
    // Mode and data pattern from the bench
    input wire logic gci,
    input wire logic phase_high,
    input wire logic [STREAMS-1:0] data_high,
    input wire logic [STREAMS-1:0] data_low,
    // Serial side pins
    output logic bit_clk_pin,
    output logic frame_pin,
    output logic [STREAMS-1:0] serial_in
);
    int bit_no;

    ////////////////////////////////////////////////////////////////////////////
    // Data and frame move mid-phase, so both clock edges see settled levels
    initial begin
        bit_clk_pin = 1'b0;
        frame_pin = 1'b1;
        serial_in = '0;
        bit_no = 0;
        forever begin
            bit_clk_pin = 1'b1;
            #(QUARTER_NS);
            serial_in = data_high;
            // Frame edge lands in the high phase when asked
            if (phase_high) frame_pin = (bit_no == 0) ? gci : !gci;
            #(QUARTER_NS);
            bit_clk_pin = 1'b0;
            #(QUARTER_NS);
            serial_in = data_low;
            if (!phase_high) frame_pin = (bit_no == 0) ? gci : !gci;
            #(QUARTER_NS);
            bit_no = (bit_no + 1) % FRAME_BITS;
        end
    end
endmodule

/* File: test/input_stream_offset_delay_bench.sv */
`timescale 1ns/10ps
module input_stream_offset_delay_bench
    import offset_pkg::*;
;
    logic clock, rst_n, wr_stb, rd_stb, out_ready, out_valid;
    logic bit_clk_pin, frame_pin, gci, phase_high;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wr_data, rd_data;
    logic [STREAMS-1:0] serial_in, out_data;
    logic [3:0] field [STREAMS];
    int n_mismatch, tests_run;

    ////////////////////////////////////////////////////////////////////////////
    // Design and far-side model
    stream_offset_top u_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .bit_clk_pin(bit_clk_pin),
        .frame_pin(frame_pin), .serial_in(serial_in), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready));
    // Opposite patterns per phase make the sampling edge visible in each bit
    serial_source u_src (.gci(gci), .phase_high(phase_high), .data_high(16'hffff),
        .data_low(16'h0000), .bit_clk_pin(bit_clk_pin), .frame_pin(frame_pin),
        .serial_in(serial_in));

    // 40 MHz system clock
    always #12.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp_v);
        tests_run++;
        if (seen !== exp_v) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", what, exp_v, seen);
        end
    endtask

    // Lands just after the edge so registered outputs have settled
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        wr_stb <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        d = rd_data;
    endtask

    // Write then read one address with no idle cycle between the strobes
    task automatic write_read(input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clock);
        wr_stb <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        q = rd_data;
    endtask

    // Waits bounded for a word, then accepts it with a one-cycle ready
    task automatic pop_word(output logic [15:0] w);
        int i;
        for (i = 0; i < 800 && out_valid !== 1'b1; i++) wait_clk(1);
        if (i == 800) begin
            n_mismatch++;
            stop_test();
        end
        w = out_data;
        @(posedge clock);
        out_ready <= 1'b1;
        @(posedge clock);
        out_ready <= 1'b0;
        // Let the buffer head settle before the caller looks at it again
        #1;
    endtask

    task automatic program_fields();
        logic [15:0] v;
        for (int j = 0; j < OFS_REGS; j++) begin
            for (int k = 0; k < 4; k++) v[4*k +: 4] = field[4*j+k];
            reg_write(ADDR_OFS0 + 4'(j), v);
        end
    endtask

    function automatic logic [15:0] exp_word(input logic g);
        logic [15:0] w;
        for (int n = 0; n < STREAMS; n++) w[n] = field[n][EDGE_BIT] ^ g;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        logic [15:0] v;
        for (int a = 3; a <= 8; a++) begin
            reg_read(4'(a), v);
            check("reset value", v, 16'h0000);
        end
        check("valid after reset", {15'h0000, out_valid}, 16'h0000);
    endtask

    task automatic t_regs();
        logic [15:0] pat [4] = '{16'h9876, 16'h5432, 16'h1098, 16'h7654};
        logic [15:0] v;
        for (int j = 0; j < OFS_REGS; j++) reg_write(ADDR_OFS0 + 4'(j), pat[j]);
        for (int j = 0; j < OFS_REGS; j++) begin
            reg_read(ADDR_OFS0 + 4'(j), v);
            check("offset register", v, pat[j]);
        end
        wait_clk(1);
        check("read data idle", rd_data, 16'h0000);
        reg_write(4'hf, 16'hffff);
        reg_read(4'hf, v);
        check("unmapped read", v, 16'h0000);
        write_read(4'h4, 16'h2468, v);
        check("write then read", v, 16'h2468);
    endtask

    // Stale words from the previous mode are flushed before judging
    task automatic t_edge(input logic g);
        logic [15:0] w;
        gci <= g;
        program_fields();
        reg_write(ADDR_CTRL, {14'h0000, 1'b1, g});
        repeat (5) pop_word(w);
        check("aligned word", w, exp_word(g));
    endtask

    task automatic t_phase();
        logic [15:0] st, w;
        phase_high <= 1'b1;
        wait_clk(600);
        reg_read(ADDR_STAT, st);
        check("phase high", st & 16'h0003, 16'h0003);
        phase_high <= 1'b0;
        wait_clk(600);
        reg_read(ADDR_STAT, st);
        check("phase low", st & 16'h0003, 16'h0002);
        field[0] = {3'b000, ~st[STAT_PHASE_BIT]};
        program_fields();
        repeat (5) pop_word(w);
        check("calibrated word", w, exp_word(1'b0));
    endtask

    // Consumer stalls until the buffer refuses, then drains it empty
    task automatic t_buffer();
        logic [15:0] st, w;
        wait_clk(100);
        w = out_data;
        check("stalled valid", {15'h0000, out_valid}, 16'h0001);
        wait_clk(20);
        check("stalled data", out_data, w);
        reg_write(ADDR_CTRL, 16'h0000);
        wait_clk(20);
        reg_read(ADDR_STAT, st);
        check("overrun set", st & 16'h0004, 16'h0004);
        repeat (2) pop_word(w);
        #1;
        check("drained", {15'h0000, out_valid}, 16'h0000);
        reg_write(ADDR_STAT, 16'h0004);
        reg_read(ADDR_STAT, st);
        check("overrun cleared", st & 16'h0004, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        out_ready = 1'b0;
        addr = 4'h0;
        wr_data = 16'h0000;
        gci = 1'b0;
        phase_high = 1'b1;
        n_mismatch = 0;
        tests_run = 0;
        for (int n = 0; n < STREAMS; n++) field[n] = 4'(n % 10);
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_edge(1'b1);
        t_edge(1'b0);
        t_phase();
        t_buffer();
        stop_test();
    end
endmodule
